// ===== core/flsc_pkg.sv
// package: constants and types for the flash led status and mode control block
package flsc_pkg;

    // status register sub-address and field positions
    localparam logic [7:0] STAT_ADDR       = 8'h03;
    localparam int         BIT_FLASH_RUN   = 6;
    localparam int         BIT_OPEN_FAULT  = 5;
    localparam int         BIT_TEMP_WARN   = 4;
    localparam int         BIT_TEMP_EXCESS = 3;
    localparam int         BIT_OVERHEAT    = 2;
    localparam int         BIT_OUT_NOT_OK  = 0;
    localparam logic [7:0] STAT_RESET      = 8'h00;

    // command bits as they arrive from the host register interface
    localparam int         CMD_BIT_TRIGGER_ENABLE = 0;
    localparam int         CMD_BIT_TORCH   = 1;
    localparam int         CMD_BIT_POWER_ON_BIT  = 2;

    // timing at the 25 MHz logic clock
    localparam int CLK_KHZ          = 25000;
    localparam int POR_TIME_NS      = 1000;
    localparam int POR_CYCLES       = (POR_TIME_NS * CLK_KHZ + 999999) / 1000000;
    localparam int PRECHARGE_US     = 360;
    localparam int PRECHARGE_CYCLES = (PRECHARGE_US * CLK_KHZ) / 1000;
    localparam int RAMP_TIME_US     = 1200;
    localparam int RAMP_CYCLES      = (RAMP_TIME_US * CLK_KHZ) / 1000;
    localparam int ATTN_PULSE_US    = 11;
    localparam int ATTN_PULSE_CYCLES = (ATTN_PULSE_US * CLK_KHZ) / 1000;
    localparam int GLITCH_TAPS      = 4;
    // one timeout unit is 100 ms of flash on-time
    localparam int TIMEOUT_UNIT_MS  = 100;
    localparam int TIMEOUT_UNIT_CYCLES = TIMEOUT_UNIT_MS * CLK_KHZ;
    localparam int TO_W             = 4;

    // operating modes
    typedef enum logic [4:0] {
        MODE_POR      = 5'b00001,
        MODE_SHUTDOWN = 5'b00010,
        MODE_READY    = 5'b00100,
        MODE_FLASH    = 5'b01000,
        MODE_TORCH    = 5'b10000
    } flsc_mode_e;

    // analog comparator outputs, asynchronous to the logic clock
    typedef struct packed {
        logic open_led;
        logic temp_warn;
        logic temp_excess;
        logic overheat;
        logic out_ok;
    } flsc_sense_s;

    // command register write from the serial interface
    typedef struct packed {
        logic            wr;
        logic [7:0]      data;
        logic [TO_W-1:0] timeout;
    } flsc_cmd_s;

endpackage : flsc_pkg

// ===== core/flsc_sync_filter.sv
// two-stage synchroniser followed by a run-length glitch filter
`timescale 1ns/1ps
`default_nettype none
module flsc_sync_filter #(
    parameter int TAPS = 4
) (
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    input  wire logic async_i,
    output logic      level_o
);
    logic            meta_q;
    logic            sync_q;
    logic [TAPS-1:0] hist_q;
    wire             all_one  = &hist_q;
    wire             all_zero = ~|hist_q;

    // synchroniser and history shift
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            hist_q <= '0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
            hist_q <= {hist_q[TAPS-2:0], sync_q};
        end
    end

    // output moves only after a full run of equal samples
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            level_o <= 1'b0;
        end else if (all_one) begin
            level_o <= 1'b1;
        end else if (all_zero) begin
            level_o <= 1'b0;
        end
    end
endmodule : flsc_sync_filter
`default_nettype wire

// ===== core/flsc_core.sv
// status flags, mode control and flash timing of the flash led driver
`timescale 1ns/1ps
`default_nettype none
// Operation
// - flash-active bit high while flash runs
// - open led in torch/flash: fault, ready
// - open led input glitch filtered
// - temp warning sets bit, attention, continues
// - temp excess sets bit, attention, ready
// - chip overheat sets bit, attention, ready
// - start-up precharge sets then clears not-ok; here the bit stays set after precharge until a status read
// - never charged: not-ok stays, no start
// - latched flags clear on status read
// - power-on reset: ignore inputs, release pins
// - shutdown after reset or power bit cleared
// - ready: converter off, aux led allowed
// - ready entry from standby, flash, torch
// - hard trigger: duration equals pin pulse
// - current ramps over 1.2 ms
// - timeout accumulates until command write reloads
// - timeout clears trigger enable, attention
// - soft trigger by one command write; here the trigger pin must also be high
// - timed end pulses attention 11 us
// - status bit layout at sub-address 03
module flsc_core
    import flsc_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  sys_rst_i,
    input  wire flsc_pkg::flsc_sense_s sense_i,
    input  wire logic                  trigger_pin_i,
    input  wire logic                  addr_sel_i,
    input  wire flsc_pkg::flsc_cmd_s   cmd_i,
    input  wire logic                  stat_rd_i,
    output logic [7:0]                 fault_status_o,
    output logic                       trigger_enable_o,
    output logic                       attention_line_o,
    output logic                       attention_line_oe_n_o,
    output logic                       sda_release_o,
    output logic                       slave_addr_bit_o,
    output logic                       converter_en_o,
    output logic                       led_connect_o,
    output logic                       aux_led_allow_o,
    output logic                       precharge_en_o,
    output logic                       ramp_done_o,
    output flsc_pkg::flsc_mode_e       mode_o
);
    import flsc_pkg::*;

    localparam int TU_W = $clog2(TIMEOUT_UNIT_CYCLES + 1);
    localparam int PC_W = $clog2(PRECHARGE_CYCLES + 1);
    localparam int RC_W = $clog2(RAMP_CYCLES + 1);
    localparam int AP_W = $clog2(ATTN_PULSE_CYCLES + 1);
    localparam int PO_W = $clog2(POR_CYCLES + 1);

    // synchronised comparator levels and trigger pin, open led also glitch filtered
    logic open_led_open_fault;
    logic warn_f;
    logic excess_f;
    logic heat_f;
    logic outok_f;
    logic trigger_pin_f;

    // open led gets the glitch filter, the rest a plain two-stage sync
    flsc_sync_filter #(.TAPS(GLITCH_TAPS)) u_open_filt (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .async_i   (sense_i.open_led),
        .level_o   (open_led_open_fault)
    );

    logic [4:0] meta_q;
    logic [4:0] sync_q;
    wire  [4:0] raw_in = {sense_i.temp_warn, sense_i.temp_excess, sense_i.overheat,
                          sense_i.out_ok, trigger_pin_i};
    // two-flop synchronisers for remaining asynchronous inputs
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            meta_q <= 5'h00;
            sync_q <= 5'h00;
        end else begin
            meta_q <= raw_in;
            sync_q <= meta_q;
        end
    end
    assign {warn_f, excess_f, heat_f, outok_f, trigger_pin_f} = sync_q;

    // state registers
    flsc_mode_e       mode_q;
    flsc_mode_e       mode_d;
    logic [PO_W-1:0]  por_cnt_q;
    logic             addr_q;
    logic             ten_q;
    logic             pwr_q;
    logic             torch_q;
    logic             run_q;
    logic             open_q;
    logic             warn_q;
    logic             excess_q;
    logic             heat_q;
    logic             notok_q;
    logic             chg_done_q;
    logic [PC_W-1:0]  chg_cnt_q;
    logic [RC_W-1:0]  ramp_cnt_q;
    logic [TO_W-1:0]  to_units_q;
    logic [TU_W-1:0]  to_sub_q;
    logic [AP_W-1:0]  pulse_cnt_q;

    // decoded events
    wire in_por      = (mode_q == MODE_POR);
    wire active      = (mode_q == MODE_FLASH) || (mode_q == MODE_TORCH);
    wire cmd_wr      = cmd_i.wr && !in_por;
    wire cmd_ten     = cmd_i.data[CMD_BIT_TRIGGER_ENABLE];
    wire cmd_pwr     = cmd_i.data[CMD_BIT_POWER_ON_BIT];
    wire cmd_torch   = cmd_i.data[CMD_BIT_TORCH];
    wire read_clr    = stat_rd_i && !in_por;
    wire open_evt    = active && open_led_open_fault;
    wire excess_evt  = excess_f && !in_por;
    wire heat_evt    = heat_f && !in_por;
    wire warn_evt    = warn_f && !in_por;
    wire chg_fail    = !chg_done_q && (chg_cnt_q == PC_W'(PRECHARGE_CYCLES)) && !outok_f;
    wire fault_stop  = open_evt || excess_evt || heat_evt;
    wire unit_tick   = (mode_q == MODE_FLASH) && (to_sub_q == TU_W'(TIMEOUT_UNIT_CYCLES - 1));
    wire timeout_evt = unit_tick && (to_units_q <= TO_W'(1));
    wire hold_ready  = open_q | excess_q | heat_q | fault_stop;
    wire flash_go    = pwr_q && ten_q && trigger_pin_f && chg_done_q && !hold_ready;
    wire flash_stop  = !trigger_pin_f || !ten_q;
    wire flags_set   = open_q | warn_q | excess_q | heat_q | notok_q;

    // mode transitions
    always_comb begin
        mode_d = mode_q;
        unique case (mode_q)
            MODE_POR: begin
                if (por_cnt_q == PO_W'(POR_CYCLES)) begin
                    mode_d = MODE_SHUTDOWN;
                end
            end
            MODE_SHUTDOWN: begin
                if (pwr_q && chg_done_q) begin
                    mode_d = MODE_READY;
                end
            end
            MODE_READY: begin
                if (!pwr_q) begin
                    mode_d = MODE_SHUTDOWN;
                end else if (flash_go) begin
                    mode_d = MODE_FLASH;
                end else if (torch_q && chg_done_q && !hold_ready) begin
                    mode_d = MODE_TORCH;
                end
            end
            MODE_FLASH: begin
                if (!pwr_q) begin
                    mode_d = MODE_SHUTDOWN;
                end else if (flash_stop || timeout_evt || fault_stop) begin
                    mode_d = MODE_READY;
                end
            end
            MODE_TORCH: begin
                if (!pwr_q) begin
                    mode_d = MODE_SHUTDOWN;
                end else if (!torch_q || fault_stop) begin
                    mode_d = MODE_READY;
                end
            end
            default: mode_d = MODE_SHUTDOWN;
        endcase
    end

    // mode register and power-on reset timer
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mode_q    <= MODE_POR;
            por_cnt_q <= '0;
        end else begin
            mode_q <= mode_d;
            if (in_por) begin
                por_cnt_q <= por_cnt_q + PO_W'(1);
            end
        end
    end

    // address pin caught at the end of power-on reset
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            addr_q <= 1'b0;
        end else if (in_por) begin
            addr_q <= addr_sel_i;
        end
    end

    // command bits; timeout clears trigger enable
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ten_q   <= 1'b0;
            pwr_q   <= 1'b0;
            torch_q <= 1'b0;
        end else if (cmd_wr) begin
            ten_q   <= cmd_ten;
            pwr_q   <= cmd_pwr;
            torch_q <= cmd_torch;
        end else if (timeout_evt) begin
            ten_q <= 1'b0;
        end
    end

    // safety timeout: accumulates across flashes, reloaded by command write
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            to_units_q <= '0;
            to_sub_q   <= '0;
        end else if (cmd_wr) begin
            to_units_q <= cmd_i.timeout;
            to_sub_q   <= '0;
        end else if (mode_q == MODE_FLASH) begin
            if (unit_tick) begin
                to_sub_q   <= '0;
                to_units_q <= (to_units_q == '0) ? '0 : to_units_q - TO_W'(1);
            end else begin
                to_sub_q <= to_sub_q + TU_W'(1);
            end
        end
    end

    // start-up precharge window
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            chg_cnt_q  <= '0;
            chg_done_q <= 1'b0;
        end else if (!in_por && !chg_done_q && pwr_q) begin
            if (outok_f) begin
                chg_done_q <= 1'b1;
            end else if (chg_cnt_q != PC_W'(PRECHARGE_CYCLES)) begin
                chg_cnt_q <= chg_cnt_q + PC_W'(1);
            end
        end
    end

    // current ramp after flash activation
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ramp_cnt_q <= '0;
        end else if (mode_q != MODE_FLASH) begin
            ramp_cnt_q <= '0;
        end else if (ramp_cnt_q != RC_W'(RAMP_CYCLES)) begin
            ramp_cnt_q <= ramp_cnt_q + RC_W'(1);
        end
    end

    // latched flags: set wins over read clear
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            open_q   <= 1'b0;
            warn_q   <= 1'b0;
            excess_q <= 1'b0;
            heat_q   <= 1'b0;
            notok_q  <= 1'b0;
        end else begin
            open_q   <= open_evt   | (open_q   & ~read_clr);
            warn_q   <= warn_evt   | (warn_q   & ~read_clr);
            excess_q <= excess_evt | (excess_q & ~read_clr);
            heat_q   <= heat_evt   | (heat_q   & ~read_clr);
            notok_q  <= (pwr_q && !chg_done_q) | chg_fail | (notok_q & ~read_clr);
        end
    end

    // flash-active follows mode in real time
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            run_q <= 1'b0;
        end else begin
            run_q <= (mode_d == MODE_FLASH);
        end
    end

    // attention pulse after an internally timed flash end
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pulse_cnt_q <= '0;
        end else if (timeout_evt) begin
            pulse_cnt_q <= AP_W'(ATTN_PULSE_CYCLES);
        end else if (pulse_cnt_q != '0) begin
            pulse_cnt_q <= pulse_cnt_q - AP_W'(1);
        end
    end

    // registered outputs
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            fault_status_o        <= STAT_RESET;
            trigger_enable_o      <= 1'b0;
            attention_line_o      <= 1'b0;
            attention_line_oe_n_o <= 1'b1;
            sda_release_o         <= 1'b1;
            slave_addr_bit_o      <= 1'b0;
            converter_en_o        <= 1'b0;
            led_connect_o         <= 1'b0;
            aux_led_allow_o       <= 1'b0;
            precharge_en_o        <= 1'b0;
            ramp_done_o           <= 1'b0;
            mode_o                <= MODE_POR;
        end else begin
            fault_status_o                  <= STAT_RESET;
            fault_status_o[BIT_FLASH_RUN]   <= run_q;
            fault_status_o[BIT_OPEN_FAULT]  <= open_q;
            fault_status_o[BIT_TEMP_WARN]   <= warn_q;
            fault_status_o[BIT_TEMP_EXCESS] <= excess_q;
            fault_status_o[BIT_OVERHEAT]    <= heat_q;
            fault_status_o[BIT_OUT_NOT_OK]  <= notok_q;
            trigger_enable_o      <= ten_q;
            attention_line_o      <= 1'b0;
            attention_line_oe_n_o <= in_por | ~(flags_set | (pulse_cnt_q != '0));
            sda_release_o         <= in_por;
            slave_addr_bit_o      <= addr_q;
            converter_en_o        <= active;
            led_connect_o         <= active;
            aux_led_allow_o       <= (mode_q == MODE_READY);
            precharge_en_o        <= pwr_q && !chg_done_q && !chg_fail && !in_por;
            ramp_done_o           <= (ramp_cnt_q == RC_W'(RAMP_CYCLES));
            mode_o                <= mode_q;
        end
    end
endmodule : flsc_core
`default_nettype wire

// ===== tb/flsc_core_asserts.sv
// assertion checker for the flash led status and mode control core
`timescale 1ns/1ps
`default_nettype none
module flsc_core_asserts (
    input wire logic                  clk_i,
    input wire logic                  sys_rst_i,
    input wire flsc_pkg::flsc_sense_s sense_i,
    input wire logic                  trigger_pin_i,
    input wire logic                  stat_rd_i,
    input wire logic [7:0]            fault_status_o,
    input wire logic                  attention_line_oe_n_o,
    input wire logic                  sda_release_o,
    input wire logic                  converter_en_o,
    input wire logic                  aux_led_allow_o,
    input wire logic                  precharge_en_o,
    input wire flsc_pkg::flsc_mode_e  mode_o
);
    import flsc_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    // no comparator event left in the sync and filter pipeline
    sequence quiet_sense;
        (sense_i[4:1] == 4'h0) [*8];
    endsequence
    sequence read_when_quiet;
        quiet_sense ##0 stat_rd_i;
    endsequence

    // properties on the status image, attention pin and mode
    a_por_hold_len: assert property ($fell(sys_rst_i) |-> (mode_o == MODE_POR) [*8])
        else $error("power-on phase left too early");
    a_por_pins_free: assert property (mode_o == MODE_POR |-> sda_release_o && attention_line_oe_n_o)
        else $error("pins driven during power-on phase");
    a_run_bit_on: assert property ((mode_o == MODE_FLASH) [*3] |-> fault_status_o[BIT_FLASH_RUN])
        else $error("flash run bit low during flash");
    a_run_bit_off: assert property ((mode_o != MODE_FLASH) [*3] |-> !fault_status_o[BIT_FLASH_RUN])
        else $error("flash run bit high outside flash");
    a_unused_bits_zero: assert property (fault_status_o[7] == 1'b0 && fault_status_o[1] == 1'b0)
        else $error("unused status bits not zero");
    a_warn_pulls_attn: assert property ($rose(fault_status_o[BIT_TEMP_WARN]) |-> ##[0:2] !attention_line_oe_n_o)
        else $error("warning did not pull attention low");
    a_fault_stops_led: assert property ($rose(fault_status_o[BIT_OPEN_FAULT] || fault_status_o[BIT_TEMP_EXCESS]
        || fault_status_o[BIT_OVERHEAT]) |-> ##[0:3] !converter_en_o)
        else $error("fault did not stop the converter");
    a_ready_outputs: assert property ((mode_o == MODE_READY) [*3] |-> !converter_en_o && aux_led_allow_o)
        else $error("ready mode outputs wrong");
    a_read_clears: assert property (read_when_quiet |-> ##2 fault_status_o[5:2] == 4'h0)
        else $error("status read did not clear latched flags");
    a_pin_low_stops: assert property ((!trigger_pin_i) [*6] |-> mode_o != MODE_FLASH)
        else $error("flash continues with trigger pin low");
    a_startup_not_ok: assert property ($rose(precharge_en_o) |-> ##[0:3] fault_status_o[BIT_OUT_NOT_OK])
        else $error("output not ok bit not set at start-up");
endmodule : flsc_core_asserts

bind flsc_core flsc_core_asserts i_flsc_core_asserts (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .sense_i(sense_i), .trigger_pin_i(trigger_pin_i),
    .stat_rd_i(stat_rd_i), .fault_status_o(fault_status_o),
    .attention_line_oe_n_o(attention_line_oe_n_o), .sda_release_o(sda_release_o),
    .converter_en_o(converter_en_o), .aux_led_allow_o(aux_led_allow_o),
    .precharge_en_o(precharge_en_o), .mode_o(mode_o)
);
`default_nettype wire

// ===== tb/flsc_host_model.sv
// host side model: command writes, status reads and trigger pin
`timescale 1ns/1ps
`default_nettype none
module flsc_host_model (
    input  wire logic                clk_i,
    output var  flsc_pkg::flsc_cmd_s cmd_o,
    output var  logic                stat_rd_o,
    output var  logic                trigger_pin_o
);
    import flsc_pkg::*;
    // idle host at time zero
    initial begin
        cmd_o         = '0;
        stat_rd_o     = 1'b0;
        trigger_pin_o = 1'b0;
    end
    // one-cycle write, timeout always sent with the command bits
    task automatic write_cmd(input logic [7:0] data, input logic [TO_W-1:0] tmo);
        @(posedge clk_i);
        cmd_o <= '{wr: 1'b1, data: data, timeout: tmo};
        @(posedge clk_i);
        cmd_o <= '{wr: 1'b0, data: ~data, timeout: ~tmo}; // released bus loses the value
    endtask : write_cmd
    // one-cycle status read strobe
    task automatic read_stat();
        @(posedge clk_i);
        stat_rd_o <= 1'b1;
        @(posedge clk_i);
        stat_rd_o <= 1'b0;
    endtask : read_stat
    // trigger pin level, held high for bus-started flashes
    task automatic set_pin(input logic v);
        @(posedge clk_i);
        trigger_pin_o <= v;
    endtask : set_pin
endmodule : flsc_host_model
`default_nettype wire

// ===== tb/flsc_core_tb.sv
// self-checking testbench for the flash led status and mode control core
`timescale 1ns/1ps
`default_nettype none
module flsc_core_tb;
    import flsc_pkg::*;
    logic        clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    flsc_sense_s sense_i = '0;
    logic        addr_sel_i = 1'b1;
    flsc_cmd_s   cmd_i;
    logic        stat_rd_i, trigger_pin_i, trigger_enable_o, attention_line_oe_n_o;
    logic        sda_release_o, slave_addr_bit_o, converter_en_o, aux_led_allow_o;
    logic        precharge_en_o, ramp_done_o, attention_line_o, led_connect_o;
    logic [7:0]  fault_status_o;
    flsc_mode_e  mode_o;
    int          n_errors = 0;
    int          cmp_count = 0;
    int          k;
    int          sidx[3] = '{4, 2, 1};
    int          sbit[3] = '{BIT_OPEN_FAULT, BIT_TEMP_EXCESS, BIT_OVERHEAT};

    // 25 MHz clock
    always #20 clk_i = ~clk_i;

    flsc_host_model i_flsc_host_model (.clk_i(clk_i), .cmd_o(cmd_i), .stat_rd_o(stat_rd_i),
        .trigger_pin_o(trigger_pin_i));
    flsc_core i_flsc_core (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .sense_i(sense_i),
        .trigger_pin_i(trigger_pin_i), .addr_sel_i(addr_sel_i), .cmd_i(cmd_i),
        .stat_rd_i(stat_rd_i), .fault_status_o(fault_status_o),
        .trigger_enable_o(trigger_enable_o), .attention_line_o(attention_line_o),
        .attention_line_oe_n_o(attention_line_oe_n_o), .sda_release_o(sda_release_o),
        .slave_addr_bit_o(slave_addr_bit_o), .converter_en_o(converter_en_o),
        .led_connect_o(led_connect_o), .aux_led_allow_o(aux_led_allow_o),
        .precharge_en_o(precharge_en_o), .ramp_done_o(ramp_done_o), .mode_o(mode_o));

    // compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    // verdict and end of run
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results
    task automatic cycles(input int n);
        repeat (n) @(posedge clk_i);
    endtask : cycles
    // bounded wait for a mode, a run-out ends the test
    task automatic wait_mode(input flsc_mode_e m);
        int i = 0;
        while (mode_o !== m && i < 40000) begin
            @(posedge clk_i);
            i++;
        end
        chk(8'(mode_o), 8'(m), "mode");
        if (mode_o !== m) begin
            results();
        end
    endtask : wait_mode
    // hold one comparator level high for n cycles
    task automatic pulse_sense(input int idx, input int n);
        @(posedge clk_i);
        sense_i[idx] <= 1'b1;
        cycles(n);
        sense_i[idx] <= 1'b0;
    endtask : pulse_sense
    // quiet read, flags and attention released
    task automatic rd_clear();
        cycles(10);
        i_flsc_host_model.read_stat();
        cycles(3);
        chk(fault_status_o, 8'h00, "status after read");
        chk(attention_line_oe_n_o, 1'b1, "attention released");
    endtask : rd_clear

    // main sequence
    initial begin
        cycles(4);
        chk({sda_release_o, attention_line_oe_n_o}, 8'h03, "pins in reset");
        sys_rst_i <= 1'b0;
        wait_mode(MODE_SHUTDOWN);
        chk(fault_status_o, STAT_RESET, "reset status");
        addr_sel_i <= 1'b0;
        cycles(3);
        chk(slave_addr_bit_o, 1'b1, "address strap");
        i_flsc_host_model.write_cmd(8'h04, 4'hF);
        cycles(20);
        chk({precharge_en_o, fault_status_o[BIT_OUT_NOT_OK]}, 8'h03, "precharge");
        sense_i.out_ok <= 1'b1;
        wait_mode(MODE_READY);
        chk({converter_en_o, aux_led_allow_o}, 8'h01, "ready outputs");
        rd_clear();
        pulse_sense(3, 6);
        cycles(10);
        chk({mode_o == MODE_READY, fault_status_o[BIT_TEMP_WARN], attention_line_oe_n_o,
            attention_line_o}, 8'h0C, "warning");
        rd_clear();
        i_flsc_host_model.set_pin(1'b1);
        i_flsc_host_model.write_cmd(8'h05, 4'hF);
        wait_mode(MODE_FLASH);
        cycles(3);
        chk({fault_status_o[BIT_FLASH_RUN], converter_en_o, trigger_enable_o, ramp_done_o},
            8'h0E, "flash on");
        pulse_sense(4, 2);
        cycles(12);
        chk({mode_o == MODE_FLASH, fault_status_o[BIT_OPEN_FAULT]}, 8'h02, "glitch");
        cycles(RAMP_CYCLES);
        chk(ramp_done_o, 1'b1, "ramp done");
        i_flsc_host_model.set_pin(1'b0);
        wait_mode(MODE_READY);
        cycles(3);
        chk(fault_status_o, 8'h00, "flash end");
        // torch on and off again by command writes
        i_flsc_host_model.write_cmd(8'h06, 4'hF);
        wait_mode(MODE_TORCH);
        chk({converter_en_o, led_connect_o, aux_led_allow_o}, 8'h06, "torch outputs");
        i_flsc_host_model.write_cmd(8'h04, 4'hF);
        wait_mode(MODE_READY);
        for (k = 0; k < 3; k++) begin
            i_flsc_host_model.set_pin(1'b1);
            i_flsc_host_model.write_cmd(8'h05, 4'hF);
            wait_mode(MODE_FLASH);
            pulse_sense(sidx[k], 12);
            chk({mode_o == MODE_READY, fault_status_o[sbit[k]], attention_line_oe_n_o},
                8'h06, "fault");
            i_flsc_host_model.set_pin(1'b0);
            rd_clear();
        end
        i_flsc_host_model.write_cmd(8'h00, 4'hF);
        wait_mode(MODE_SHUTDOWN);
        // second reset so that start-up precharge runs again, output held shorted
        sense_i.out_ok <= 1'b0;
        sys_rst_i <= 1'b1;
        cycles(4);
        sys_rst_i <= 1'b0;
        wait_mode(MODE_SHUTDOWN);
        chk(fault_status_o, STAT_RESET, "status after reset");
        chk(sda_release_o, 1'b0, "sda driven after reset");
        i_flsc_host_model.write_cmd(8'h04, 4'hF);
        cycles(9100);
        chk({mode_o == MODE_SHUTDOWN, fault_status_o[BIT_OUT_NOT_OK], attention_line_oe_n_o,
            precharge_en_o}, 8'h0C, "no start");
        results();
    end
endmodule : flsc_core_tb
`default_nettype wire
